// File: verilog/smc_pkg.sv
// Constants, field layout and state encoding of the standby mode controller
// Behaviour
// - An unmasked request ends light standby and vectors if qualified.
// - A reset in light standby ends it and restarts from the reset vector.
// - Wake from light standby resumes after 8 clocks vectored, 2 otherwise.
// - Deep standby is entered only by stop while on the main clock.
// - Stop with a request pending resumes after the oscillation wait.
// - Deep standby gates CPU clock and flash and stops the main clocks.
// - Deep standby keeps sub and slow clocks, RAM and port latches as is.
// - In deep standby an external subsystem clock simply follows its source.
// - In deep standby event counter A counts only on its own pin clock.
// - In deep standby event counter B counts only on its own pin clock.
// - In deep standby interval timer A runs only on a running counter A.
// - In deep standby timer B runs only on slow, slow/2^7 or slow/2^9.
// - In deep standby the watch timer runs only on the subsystem clock.
`default_nettype none

package smc_pkg;

  // ****************
  // Register map
  // ****************
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'hc;
  localparam int          ADDR_LSB        = 2;
  localparam int          ADDR_MSB        = 3;

  // ****************
  // Control register fields
  // ****************
  localparam int CTRL_W            = 15;
  localparam int F_OSC_STABILIZATION_SELECT_LO         = 0;
  localparam int F_OSC_STABILIZATION_SELECT_HI         = 2;
  localparam int F_FAST_OSC        = 3;
  localparam int F_MAIN_XTAL       = 4;
  localparam int F_EXT_MAIN        = 5;
  localparam int F_SUB_XTAL        = 6;
  localparam int F_SLOW_OSC        = 7;
  localparam int F_CNT_A_PIN       = 8;
  localparam int F_CNT_A_RUN       = 9;
  localparam int F_CNT_B_PIN       = 10;
  localparam int F_TMR_A_CNT       = 11;
  localparam int F_TMR_B_LO        = 12;
  localparam int F_TMR_B_HI        = 13;
  localparam int F_WATCH_SUB       = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0098;

  // Interval timer B clock source codes
  localparam logic [1:0] TMR_B_SLOW      = 2'h0;
  localparam logic [1:0] TMR_B_SLOW_DIV7 = 2'h1;
  localparam logic [1:0] TMR_B_SLOW_DIV9 = 2'h2;

  // ****************
  // Event bits of the interrupt status register
  // ****************
  localparam int EVT_W           = 5;
  localparam int EVT_HALT_ENTER  = 0;
  localparam int EVT_STOP_ENTER  = 1;
  localparam int EVT_RESUMED     = 2;
  localparam int EVT_STOP_REFUSE = 3;
  localparam int EVT_RESET_WAKE  = 4;

  // ****************
  // Timing
  // ****************
  localparam int          WAIT_W         = 16;
  localparam logic [WAIT_W-1:0] RESUME_VECTOR_CLKS = 16'h0008;
  localparam logic [WAIT_W-1:0] RESUME_NEXT_CLKS   = 16'h0002;
  localparam logic [2:0]  OSC_STABILIZATION_SELECT_MAX       = 3'h4;

  // ****************
  // Controller states, Gray coded along run-halt-stop-wake
  // ****************
  typedef enum logic [1:0] {
    SMC_RUN  = 2'b00,
    SMC_HALT = 2'b01,
    SMC_STOP = 2'b11,
    SMC_WAKE = 2'b10
  } smc_state_t;

endpackage

`default_nettype wire

// File: verilog/smc_wake_if.sv
// Wake request qualifiers passed between the controller and its decoder
`default_nettype none

interface smc_wake_if;
  logic irq_request;
  logic irq_mask_flag;
  logic irq_priority_flag;
  logic global_irq_enable;
  logic in_service_priority_flag;
  logic wake;
  logic vector;

  modport decoder (
    input  irq_request, irq_mask_flag, irq_priority_flag,
           global_irq_enable, in_service_priority_flag,
    output wake, vector
  );

  modport ctrl (
    output irq_request, irq_mask_flag, irq_priority_flag,
           global_irq_enable, in_service_priority_flag,
    input  wake, vector
  );
endinterface

`default_nettype wire

// File: verilog/smc_wake_decode.sv
// Decides whether a request wakes the core and whether it vectors
`default_nettype none

module smc_wake_decode (
  smc_wake_if.decoder wk
);

  // ****************
  // Wake and acknowledge qualification
  // ****************
  assign wk.wake   = wk.irq_request & ~wk.irq_mask_flag;
  assign wk.vector = wk.global_irq_enable &
                     (~wk.irq_priority_flag |
                      wk.in_service_priority_flag);

endmodule

`default_nettype wire

// File: verilog/smc_wait_timer.sv
// Down counter that times the resume wait
`default_nettype none

module smc_wait_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  input  wire logic         run,
  // Status
  output logic              done
);

  logic [W-1:0] remain;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (run && remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Last cycle of the wait
  assign done = run && !load && (remain <= {{(W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// File: verilog/smc_top.sv
// Standby mode controller with AHB-Lite register access
`default_nettype none

module smc_top #(
  parameter int OSC_WAIT_BASE = 256
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // CPU core
  input  wire logic        halt_instr,
  input  wire logic        stop_instr,
  input  wire logic        cpu_on_main_clock,
  input  wire logic        sys_reset_req,
  // Interrupt controller
  input  wire logic        irq_request,
  input  wire logic        irq_mask_flag,
  input  wire logic        irq_priority_flag,
  input  wire logic        global_irq_enable,
  input  wire logic        in_service_priority_flag,
  // Core control
  output logic             cpu_clock_enable,
  output logic             flash_enable,
  output logic             resume_vector,
  output logic             resume_next,
  output logic             reset_vector_fetch,
  output logic      [1:0]  standby_mode,
  // Clock sources
  output logic             internal_fast_osc_enable,
  output logic             crystal_main_osc_enable,
  output logic             ext_main_clock_accept,
  output logic             crystal_sub_osc_enable,
  output logic             ext_sub_clock_follow,
  output logic             internal_slow_osc_enable,
  // Peripheral clock gates
  output logic             event_counter_a_enable,
  output logic             event_counter_b_enable,
  output logic             interval_timer_a_enable,
  output logic             interval_timer_b_enable,
  output logic             watch_timer_enable,
  // Interrupt
  output logic             irq
);

  // ****************
  // Declarations
  // ****************
  localparam int W = smc_pkg::WAIT_W;

  smc_pkg::smc_state_t             state;
  smc_pkg::smc_state_t             next_state;
  logic [smc_pkg::CTRL_W-1:0]      ctrl;
  logic [smc_pkg::EVT_W-1:0]       irq_status;
  logic [smc_pkg::EVT_W-1:0]       irq_mask;
  logic [smc_pkg::EVT_W-1:0]       evt;
  logic [smc_pkg::EVT_W-1:0]       evt_clear;
  logic                            wr_pend;
  logic [3:0]                      wr_addr;
  logic                            acc;
  logic [3:0]                      acc_addr;
  logic [31:0]                     next_rdata;
  logic                            vec_latched;
  logic                            next_vec;
  logic                            wait_load;
  logic [W-1:0]                    wait_count;
  logic                            wait_done;
  logic [W-1:0]                    osc_wait;
  logic [2:0]                      osc_stabilization_select_sel;
  logic                            in_stop;

  smc_wake_if wk ();

  // ****************
  // Wake qualification and resume wait
  // ****************
  assign wk.irq_request              = irq_request;
  assign wk.irq_mask_flag            = irq_mask_flag;
  assign wk.irq_priority_flag        = irq_priority_flag;
  assign wk.global_irq_enable        = global_irq_enable;
  assign wk.in_service_priority_flag = in_service_priority_flag;

  smc_wake_decode u_decode (
    .wk (wk.decoder)
  );

  smc_wait_timer #(
    .W (W)
  ) u_wait (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (wait_load),
    .count   (wait_count),
    .run     (state == smc_pkg::SMC_WAKE),
    .done    (wait_done)
  );

  // Oscillation stabilization wait chosen by software
  always_comb begin
    osc_stabilization_select_sel = ctrl[smc_pkg::F_OSC_STABILIZATION_SELECT_HI:smc_pkg::F_OSC_STABILIZATION_SELECT_LO];
    if (osc_stabilization_select_sel > smc_pkg::OSC_STABILIZATION_SELECT_MAX) begin
      osc_stabilization_select_sel = smc_pkg::OSC_STABILIZATION_SELECT_MAX;
    end
    osc_wait = W'(OSC_WAIT_BASE) << osc_stabilization_select_sel;
  end

  // ****************
  // Standby state machine
  // ****************
  always_comb begin
    next_state = state;
    next_vec   = vec_latched;
    wait_load  = 1'b0;
    wait_count = smc_pkg::RESUME_NEXT_CLKS;
    evt        = '0;
    if (sys_reset_req) begin
      next_state = smc_pkg::SMC_RUN;
      if (state != smc_pkg::SMC_RUN) begin
        evt[smc_pkg::EVT_RESET_WAKE] = 1'b1;
      end
    end else begin
      case (state)
        smc_pkg::SMC_RUN: begin
          if (stop_instr) begin
            if (!cpu_on_main_clock) begin
              evt[smc_pkg::EVT_STOP_REFUSE] = 1'b1;
            end else if (wk.wake) begin
              next_state = smc_pkg::SMC_WAKE;
              next_vec   = wk.vector;
              wait_load  = 1'b1;
              wait_count = osc_wait;
              evt[smc_pkg::EVT_HALT_ENTER] = 1'b1;
            end else begin
              next_state = smc_pkg::SMC_STOP;
              evt[smc_pkg::EVT_STOP_ENTER] = 1'b1;
            end
          end else if (halt_instr) begin
            next_state = smc_pkg::SMC_HALT;
            evt[smc_pkg::EVT_HALT_ENTER] = 1'b1;
          end
        end
        smc_pkg::SMC_HALT: begin
          if (wk.wake) begin
            next_state = smc_pkg::SMC_WAKE;
            next_vec   = wk.vector;
            wait_load  = 1'b1;
            wait_count = wk.vector ? smc_pkg::RESUME_VECTOR_CLKS
                                   : smc_pkg::RESUME_NEXT_CLKS;
          end
        end
        smc_pkg::SMC_STOP: begin
          if (wk.wake) begin
            next_state = smc_pkg::SMC_WAKE;
            next_vec   = wk.vector;
            wait_load  = 1'b1;
            wait_count = osc_wait;
          end
        end
        smc_pkg::SMC_WAKE: begin
          if (wait_done) begin
            next_state = smc_pkg::SMC_RUN;
            evt[smc_pkg::EVT_RESUMED] = 1'b1;
          end
        end
        default: begin
          next_state = smc_pkg::SMC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state       <= smc_pkg::SMC_RUN;
      vec_latched <= 1'b0;
    end else begin
      state       <= next_state;
      vec_latched <= next_vec;
    end
  end

  // Resume and reset pulses toward the core
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resume_vector      <= 1'b0;
      resume_next        <= 1'b0;
      reset_vector_fetch <= 1'b0;
    end else begin
      resume_vector      <= evt[smc_pkg::EVT_RESUMED] & vec_latched;
      resume_next        <= evt[smc_pkg::EVT_RESUMED] & ~vec_latched;
      reset_vector_fetch <= sys_reset_req;
    end
  end

  // ****************
  // Clock and peripheral gating
  // ****************
  assign in_stop = (next_state == smc_pkg::SMC_STOP);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      standby_mode             <= smc_pkg::SMC_RUN;
      cpu_clock_enable         <= 1'b1;
      flash_enable             <= 1'b1;
      internal_fast_osc_enable <= smc_pkg::CTRL_RESET[smc_pkg::F_FAST_OSC];
      crystal_main_osc_enable  <= smc_pkg::CTRL_RESET[smc_pkg::F_MAIN_XTAL];
      ext_main_clock_accept    <= smc_pkg::CTRL_RESET[smc_pkg::F_EXT_MAIN];
      crystal_sub_osc_enable   <= smc_pkg::CTRL_RESET[smc_pkg::F_SUB_XTAL];
      internal_slow_osc_enable <= smc_pkg::CTRL_RESET[smc_pkg::F_SLOW_OSC];
      ext_sub_clock_follow     <= 1'b1;
    end else begin
      standby_mode             <= next_state;
      cpu_clock_enable         <= next_state == smc_pkg::SMC_RUN;
      flash_enable             <= next_state == smc_pkg::SMC_RUN;
      internal_fast_osc_enable <= ctrl[smc_pkg::F_FAST_OSC] & ~in_stop;
      crystal_main_osc_enable  <= ctrl[smc_pkg::F_MAIN_XTAL] & ~in_stop;
      ext_main_clock_accept    <= ctrl[smc_pkg::F_EXT_MAIN] & ~in_stop;
      // Sub and slow sources ignore the standby state
      crystal_sub_osc_enable   <= ctrl[smc_pkg::F_SUB_XTAL];
      internal_slow_osc_enable <= ctrl[smc_pkg::F_SLOW_OSC];
      ext_sub_clock_follow     <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      event_counter_a_enable  <= 1'b1;
      event_counter_b_enable  <= 1'b1;
      interval_timer_a_enable <= 1'b1;
      interval_timer_b_enable <= 1'b1;
      watch_timer_enable      <= 1'b1;
    end else begin
      event_counter_a_enable  <= ~in_stop | ctrl[smc_pkg::F_CNT_A_PIN];
      event_counter_b_enable  <= ~in_stop | ctrl[smc_pkg::F_CNT_B_PIN];
      interval_timer_a_enable <= ~in_stop |
        (ctrl[smc_pkg::F_TMR_A_CNT] & ctrl[smc_pkg::F_CNT_A_RUN] &
         ctrl[smc_pkg::F_CNT_A_PIN]);
      interval_timer_b_enable <= ~in_stop |
        (ctrl[smc_pkg::F_TMR_B_HI:smc_pkg::F_TMR_B_LO] ==
           smc_pkg::TMR_B_SLOW) |
        (ctrl[smc_pkg::F_TMR_B_HI:smc_pkg::F_TMR_B_LO] ==
           smc_pkg::TMR_B_SLOW_DIV7) |
        (ctrl[smc_pkg::F_TMR_B_HI:smc_pkg::F_TMR_B_LO] ==
           smc_pkg::TMR_B_SLOW_DIV9);
      watch_timer_enable      <= ~in_stop | ctrl[smc_pkg::F_WATCH_SUB];
    end
  end

  // ****************
  // AHB-Lite slave
  // ****************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & htrans[1] & hready;
  assign acc_addr  = {haddr[smc_pkg::ADDR_MSB:smc_pkg::ADDR_LSB], 2'b00};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= acc & hwrite;
      wr_addr <= acc_addr;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (acc_addr == smc_pkg::ADDR_CTRL) begin
      next_rdata[smc_pkg::CTRL_W-1:0] = ctrl;
    end else if (acc_addr == smc_pkg::ADDR_STATUS) begin
      next_rdata[1:0] = state;
      next_rdata[2]   = cpu_on_main_clock;
    end else if (acc_addr == smc_pkg::ADDR_IRQ_STATUS) begin
      next_rdata[smc_pkg::EVT_W-1:0] = irq_status;
    end else if (acc_addr == smc_pkg::ADDR_IRQ_MASK) begin
      next_rdata[smc_pkg::EVT_W-1:0] = irq_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= '0;
    end else if (acc && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl <= smc_pkg::CTRL_RESET;
    end else if (wr_pend && wr_addr == smc_pkg::ADDR_CTRL) begin
      ctrl <= hwdata[smc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask <= '0;
    end else if (wr_pend && wr_addr == smc_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= hwdata[smc_pkg::EVT_W-1:0];
    end
  end

  // ****************
  // Sticky events, write one to clear, new event wins
  // ****************
  assign evt_clear = (wr_pend && wr_addr == smc_pkg::ADDR_IRQ_STATUS) ?
                     hwdata[smc_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~evt_clear) | evt;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// File: dv/smc_core_model.sv
// Behavioural CPU core and interrupt controller facing the controller
`default_nettype none
module smc_core_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Commands from the bench
  input  wire logic       do_halt,
  input  wire logic       do_stop,
  input  wire logic       req_raise,
  input  wire logic [3:0] qual,
  input  wire logic       on_main,
  input  wire logic       rst_req,
  // Resume indications from the controller
  input  wire logic       resume_vector,
  input  wire logic       resume_next,
  input  wire logic       reset_vector_fetch,
  // Towards the controller
  output logic            halt_instr,
  output logic            stop_instr,
  output logic            cpu_on_main_clock,
  output logic            sys_reset_req,
  output logic            irq_request,
  output logic            irq_mask_flag,
  output logic            irq_priority_flag,
  output logic            global_irq_enable,
  output logic            in_service_priority_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Instruction triggers and request latch
  // ****************
  initial begin
    {halt_instr, stop_instr, cpu_on_main_clock, sys_reset_req} = '0;
    {irq_request, irq_mask_flag, irq_priority_flag} = '0;
    {global_irq_enable, in_service_priority_flag} = '0;
  end
  always @(posedge sys_clk) begin
    halt_instr <= do_halt && !srst;
    stop_instr <= do_stop && !srst;
    sys_reset_req <= rst_req && !srst;
    cpu_on_main_clock <= on_main;
    if (req_raise) begin
      irq_request <= 1'b1;
      {irq_mask_flag, irq_priority_flag, global_irq_enable,
       in_service_priority_flag} <= qual;
    end else if (resume_vector || resume_next || reset_vector_fetch) begin
      // Request is taken once the core resumes or restarts
      irq_request <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: dv/smc_top_chk.sv
// Concurrent checks on the standby controller ports
`default_nettype none
module smc_top_chk (
  // Clock, reset and core side inputs
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       halt_instr,
  input wire logic       stop_instr,
  input wire logic       cpu_on_main_clock,
  input wire logic       sys_reset_req,
  input wire logic       irq_request,
  input wire logic       irq_mask_flag,
  input wire logic       irq_priority_flag,
  input wire logic       global_irq_enable,
  input wire logic       in_service_priority_flag,
  // Controller outputs
  input wire logic       cpu_clock_enable,
  input wire logic       flash_enable,
  input wire logic       resume_vector,
  input wire logic       resume_next,
  input wire logic       reset_vector_fetch,
  input wire logic [1:0] standby_mode,
  input wire logic       internal_fast_osc_enable,
  input wire logic       crystal_main_osc_enable,
  input wire logic       ext_main_clock_accept,
  input wire logic       crystal_sub_osc_enable,
  input wire logic       internal_slow_osc_enable,
  input wire logic       ext_sub_clock_follow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Properties
  // ****************
  logic wake_q;
  logic vec_q;
  assign wake_q = standby_mode == 2'b01 && irq_request && !irq_mask_flag
                  && !sys_reset_req;
  assign vec_q = global_irq_enable
                 && (!irq_priority_flag || in_service_priority_flag);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  gate_off_a: assert property (
    standby_mode != 2'b00 |-> !cpu_clock_enable && !flash_enable)
    else $error("cpu clock running in standby");
  osc_off_a: assert property (standby_mode == 2'b11 |->
    !internal_fast_osc_enable && !crystal_main_osc_enable
    && !ext_main_clock_accept) else $error("main clock alive in stop");
  clk_keep_a: assert property ($rose(standby_mode == 2'b11) |->
    $stable(crystal_sub_osc_enable) && $stable(internal_slow_osc_enable))
    else $error("slow clocks changed on stop entry");
  stop_refuse_a: assert property (standby_mode == 2'b00
    && stop_instr && !cpu_on_main_clock && !sys_reset_req
    |=> standby_mode == 2'b00) else $error("stop taken off main clock");
  halt_enter_a: assert property (standby_mode == 2'b00
    && halt_instr && !stop_instr && !sys_reset_req
    |=> standby_mode == 2'b01) else $error("halt not entered");
  masked_hold_a: assert property (standby_mode == 2'b01
    && (!irq_request || irq_mask_flag) && !sys_reset_req
    |=> standby_mode == 2'b01) else $error("halt left without wake");
  reset_wake_a: assert property (sys_reset_req |=>
    standby_mode == 2'b00 && reset_vector_fetch)
    else $error("reset did not restart core");
  vec_wait_a: assert property (wake_q && vec_q |=>
    (standby_mode == 2'b10) [*8] ##1 standby_mode == 2'b00
    && resume_vector) else $error("vector resume timing wrong");
  next_wait_a: assert property (wake_q && !vec_q |=>
    (standby_mode == 2'b10) [*2] ##1 standby_mode == 2'b00
    && resume_next) else $error("next resume timing wrong");
  sub_follow_a: assert property (ext_sub_clock_follow)
    else $error("sub clock input not following");

  cover property (standby_mode == 2'b01 ##1 standby_mode == 2'b10);
  cover property ($rose(standby_mode == 2'b11));
  cover property (resume_vector);
endmodule
bind smc_top smc_top_chk smc_top_chk_i (.*);
`default_nettype wire

// File: dv/standby_mode_controller_tb.sv
// Self-checking bench of the standby mode controller
`default_nettype none
module standby_mode_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals, tables and tasks
  // ****************
  typedef struct packed {logic [3:0] q; logic [1:0] res;} smc_hrow_t;
  typedef struct packed {logic [31:0] ctrl; logic [6:0] en;} smc_srow_t;
  localparam int OWB = 4;
  logic        sys_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, standby_mode;
  logic [2:0]  hsize;
  logic [3:0]  qual;
  logic        do_halt, do_stop, req_raise, on_main, rst_req, saw_stop;
  logic        halt_instr, stop_instr, cpu_on_main_clock, sys_reset_req;
  logic        irq_request, irq_mask_flag, irq_priority_flag, irq;
  logic        global_irq_enable, in_service_priority_flag;
  logic        cpu_clock_enable, flash_enable, resume_vector, resume_next;
  logic        reset_vector_fetch, ext_sub_clock_follow;
  logic        internal_fast_osc_enable, crystal_main_osc_enable;
  logic        ext_main_clock_accept, crystal_sub_osc_enable;
  logic        internal_slow_osc_enable, event_counter_a_enable;
  logic        event_counter_b_enable, interval_timer_a_enable;
  logic        interval_timer_b_enable, watch_timer_enable;
  int          n_errors, check_count;
  // Quals: mask, priority, enable, in service; res: vector, next
  smc_hrow_t hrows [7] = '{'{4'h0, 2'h1}, '{4'h2, 2'h2}, '{4'h5, 2'h1},
    '{4'h4, 2'h1}, '{4'h6, 2'h1}, '{4'h7, 2'h2}, '{4'h8, 2'h0}};
  // Stop enables: cnt a, cnt b, timer a, timer b, watch, sub, slow
  smc_srow_t srows [4] = '{'{32'h3bda, 7'h53}, '{32'h5e39, 7'h2c},
    '{32'h2088, 7'h09}, '{32'h0098, 7'h09}};

  smc_top #(.OSC_WAIT_BASE(OWB)) smc_top_i (.*);
  smc_core_model smc_core_model_i (.*);
  assign hready = hreadyout;
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (standby_mode === 2'b11) saw_stop = 1'b1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic instr(input logic h, s);
    @(posedge sys_clk);
    do_halt <= h;
    do_stop <= s;
    @(posedge sys_clk);
    do_halt <= 1'b0;
    do_stop <= 1'b0;
  endtask
  task automatic raise_irq(input logic [3:0] q);
    @(posedge sys_clk);
    req_raise <= 1'b1;
    qual <= q;
    @(posedge sys_clk);
    req_raise <= 1'b0;
  endtask
  task automatic irq_is(input logic v);
    @(negedge sys_clk);
    chk(irq, v);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (standby_mode !== m && i < 2000) begin
      @(negedge sys_clk);
      i++;
    end
    chk(standby_mode, m);
  endtask
  task automatic wake(input int len, input logic vec);
    int n;
    n = 0;
    wait_mode(2'b10);
    while (standby_mode === 2'b10 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n, len);
    chk({resume_vector, resume_next}, {vec, !vec});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    sys_clk = 1'b0;
    {srst, hsel, hwrite, do_halt, do_stop, req_raise, on_main} = 7'h40;
    {rst_req, saw_stop, haddr, hwdata, htrans, qual} = '0;
    {n_errors, check_count} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk({cpu_clock_enable, flash_enable, standby_mode, irq, resume_vector,
         resume_next, reset_vector_fetch, hresp}, 9'h180);
    chk({event_counter_a_enable, event_counter_b_enable,
         interval_timer_a_enable, interval_timer_b_enable,
         watch_timer_enable, internal_fast_osc_enable,
         internal_slow_osc_enable, crystal_sub_osc_enable,
         ext_sub_clock_follow}, 9'h1fd);
    rd_chk(32'(smc_pkg::ADDR_CTRL), 32'h98);
    wr(32'(smc_pkg::ADDR_IRQ_MASK), 32'h1f);
    foreach (hrows[k]) begin
      instr(1'b1, 1'b0);
      wait_mode(2'b01);
      raise_irq(hrows[k].q);
      if (hrows[k].res !== 2'h0) begin
        wake(hrows[k].res[1] ? 8 : 2, hrows[k].res[1]);
      end else begin
        repeat (12) @(negedge sys_clk);
        chk(standby_mode, 2'b01);
        @(posedge sys_clk);
        rst_req <= 1'b1;
        @(posedge sys_clk);
        rst_req <= 1'b0;
        wait_mode(2'b00);
        chk(reset_vector_fetch, 1'b1);
      end
    end
    // Stop off the main clock is refused and flagged
    wr(32'(smc_pkg::ADDR_IRQ_STATUS), 32'h1f);
    irq_is(1'b0);
    instr(1'b0, 1'b1);
    repeat (4) @(negedge sys_clk);
    chk(standby_mode, 2'b00);
    irq_is(1'b1);
    rd_chk(32'(smc_pkg::ADDR_IRQ_STATUS), 32'h08);
    rd_chk(32'h14, 32'h0);
    wr(32'(smc_pkg::ADDR_IRQ_MASK), 32'h0);
    irq_is(1'b0);
    wr(32'(smc_pkg::ADDR_IRQ_MASK), 32'h1f);
    irq_is(1'b1);
    wr(32'(smc_pkg::ADDR_IRQ_STATUS), 32'h08);
    irq_is(1'b0);
    on_main <= 1'b1;
    foreach (srows[k]) begin
      wr(32'(smc_pkg::ADDR_CTRL), srows[k].ctrl);
      instr(1'b0, 1'b1);
      wait_mode(2'b11);
      chk({event_counter_a_enable, event_counter_b_enable,
           interval_timer_a_enable, interval_timer_b_enable,
           watch_timer_enable, crystal_sub_osc_enable,
           internal_slow_osc_enable}, srows[k].en);
      chk({internal_fast_osc_enable, crystal_main_osc_enable,
           ext_main_clock_accept, cpu_clock_enable, flash_enable,
           ext_sub_clock_follow}, 6'h01);
      raise_irq(4'h0);
      wake(OWB << srows[k].ctrl[2:0], 1'b0);
    end
    // Stop with a request already pending never reaches deep standby
    wr(32'(smc_pkg::ADDR_CTRL), 32'h009a);
    saw_stop = 1'b0;
    raise_irq(4'h2);
    instr(1'b0, 1'b1);
    wake(OWB << 2, 1'b1);
    chk(saw_stop, 1'b0);
    rd_chk(32'(smc_pkg::ADDR_IRQ_STATUS), 32'h07);
    report_and_stop();
  end
endmodule
`default_nettype wire
